// ### core/tec_pkg.sv
package tec_pkg;

   // ***************************************************
   // register map (byte addresses, one word each)
   // ***************************************************
   localparam logic [3:0] ADDR_MODE = 4'h0;
   localparam logic [3:0] ADDR_MODULO = 4'h4;
   localparam logic [3:0] ADDR_COUNT = 4'h8;
   localparam logic [3:0] ADDR_CTRL = 4'hc;

   // ***************************************************
   // field positions
   // ***************************************************
   localparam int MODE_ENABLE_BIT = 2;
   localparam int MODE_START_BIT = 3;
   localparam int MODE_SRC_LSB = 4;
   localparam int CTRL_OUT_EN_BIT = 0;
   localparam int CTRL_IRQ_BIT = 1;
   localparam int CTRL_EVENT_BIT = 2;
   localparam int CTRL_MASK_BIT = 3;
   localparam int CTRL_OUT_BIT = 4;

   // ***************************************************
   // reset values
   // ***************************************************
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] MODULO_RESET = 8'hff;

   // ***************************************************
   // count pulse source dividers (system clock cycles per pulse)
   // ***************************************************
   localparam int CLOCK_HZ = 50000000;
   localparam logic [9:0] DIV_SRC4 = 10'h0200;
   localparam logic [9:0] DIV_SRC5 = 10'h0080;
   localparam logic [9:0] DIV_SRC6 = 10'h0020;
   localparam logic [9:0] DIV_SRC7 = 10'h0008;

   // count pulse source selection (mode bits 6..4)
   typedef enum logic [2:0] {
      TEC_SRC_EVENT = 3'h0,
      TEC_SRC_DIV4 = 3'h4,
      TEC_SRC_DIV5 = 3'h5,
      TEC_SRC_DIV6 = 3'h6,
      TEC_SRC_DIV7 = 3'h7
   } tec_src_e;

   // wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } tec_wb_req_s;

endpackage

// ### core/tec_prescaler.sv
`timescale 1ns/1ns
`default_nettype none
// divides the system clock into one-cycle pulses at the selected rate, or turns rising event edges into pulses
module tec_prescaler
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic [2:0] src_i,
   input wire logic event_i,
   output logic pulse_o
);

   // ***************************************************
   // divider
   // ***************************************************
   logic [9:0] cnt_r;
   logic event_d_r;
   logic [9:0] limit;
   logic tick;
   logic event_rise;

   // select the division ratio of the internal sources
   assign limit = (src_i == 3'h4) ? tec_pkg::DIV_SRC4 :
                  (src_i == 3'h5) ? tec_pkg::DIV_SRC5 :
                  (src_i == 3'h6) ? tec_pkg::DIV_SRC6 : tec_pkg::DIV_SRC7;
   assign tick = (cnt_r >= limit - 10'h0001);
   assign event_rise = event_i & ~event_d_r;

   // free-running divider and event edge detect
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt_r <= 10'h0000;
         event_d_r <= 1'b1; // no false edge from a high idle pin after reset
         pulse_o <= 1'b0;
      end
      else
      begin
         cnt_r <= tick ? 10'h0000 : cnt_r + 10'h0001;
         event_d_r <= event_i;
         pulse_o <= src_i[2] ? tick : event_rise; // external events on rising edge
      end
   end

endmodule
`default_nettype wire

// ### core/tec_counter.sv
`timescale 1ns/1ns
`default_nettype none
// 8-bit count register with modulo compare
module tec_counter
(
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   input wire logic pulse_i,
   input wire logic [7:0] modulo_i,
   output logic [7:0] count_o,
   output logic match_o
);

   // ***************************************************
   // counter
   // ***************************************************
   logic hit;

   // match seen on the pulse taken while the count equals the modulo value
   assign hit = pulse_i & (count_o == modulo_i);

   // increment, wrap after match, clear on start
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         count_o <= 8'h00;
         match_o <= 1'b0;
      end
      else
      begin
         match_o <= hit & ~clear_i;
         if (clear_i || hit)
            count_o <= 8'h00;
         else if (pulse_i)
            count_o <= count_o + 8'h01;
      end
   end

endmodule
`default_nettype wire

// ### core/tec_top.sv
`timescale 1ns/1ns
`default_nettype none

module tec_top
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic event_in_pin_i,
   output logic square_out_pin_o,
   output logic shift_clock_o,
   output logic irq_o
);

   // ***************************************************
   // reset release
   // ***************************************************
   logic rst_meta_r;
   logic rst_n_r;

   // two-flop release of the asynchronous reset
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rst_meta_r <= 1'b0;
         rst_n_r <= 1'b0;
      end
      else
      begin
         rst_meta_r <= 1'b1;
         rst_n_r <= rst_meta_r;
      end
   end

   // ***************************************************
   // bus decode
   // ***************************************************
   tec_pkg::tec_wb_req_s req;
   logic access;
   logic wr;
   logic rd;
   logic wr_mode;
   logic wr_modulo;
   logic wr_ctrl;
   logic rd_ctrl;

   // bundle the request and decode the strobes
   assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i,
                  sel: wb_sel_i, dat: wb_dat_i};
   assign access = req.cyc & req.stb & ~wb_ack_o;
   assign wr = access & req.we & req.sel[0];
   assign rd = access & ~req.we;
   assign wr_mode = wr & (req.adr == tec_pkg::ADDR_MODE);
   assign wr_modulo = wr & (req.adr == tec_pkg::ADDR_MODULO);
   assign wr_ctrl = wr & (req.adr == tec_pkg::ADDR_CTRL);
   assign rd_ctrl = rd & (req.adr == tec_pkg::ADDR_CTRL);

   // ***************************************************
   // registers
   // ***************************************************
   logic [7:0] timer_mode_reg_r;
   logic [7:0] timer_mode_reg_nxt;
   logic [7:0] modulo_reg_r;
   logic square_out_enable_flag_r;
   logic toggle_output_flop_r;
   logic timer_irq_flag_r;
   logic irq_mask_r;
   logic start_r;
   logic match;
   logic [7:0] count_reg;
   logic pulse;
   logic count_pulse;
   logic irq_set_sw;
   logic irq_clr_sw;

   // next mode value; the start bit never stays set past one cycle
   always_comb
   begin
      timer_mode_reg_nxt = timer_mode_reg_r;
      timer_mode_reg_nxt[tec_pkg::MODE_START_BIT] = 1'b0;
      if (wr_mode)
         timer_mode_reg_nxt = req.dat[7:0];
   end

   // software set/clear of the interrupt flag
   assign irq_set_sw = wr_ctrl & req.dat[tec_pkg::CTRL_IRQ_BIT];
   assign irq_clr_sw = (wr_ctrl & ~req.dat[tec_pkg::CTRL_IRQ_BIT]) | rd_ctrl;

   // mode, modulo, start pulse and control flags
   always_ff @(posedge clock_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         timer_mode_reg_r <= tec_pkg::MODE_RESET;
         modulo_reg_r <= tec_pkg::MODULO_RESET;
         square_out_enable_flag_r <= 1'b0;
         irq_mask_r <= 1'b0;
         start_r <= 1'b0;
      end
      else
      begin
         timer_mode_reg_r <= timer_mode_reg_nxt;
         start_r <= wr_mode & req.dat[tec_pkg::MODE_START_BIT];
         if (wr_modulo)
            modulo_reg_r <= req.dat[7:0];
         if (wr_ctrl)
         begin
            square_out_enable_flag_r <= req.dat[tec_pkg::CTRL_OUT_EN_BIT];
            irq_mask_r <= req.dat[tec_pkg::CTRL_MASK_BIT];
         end
      end
   end

   // toggle flop and sticky interrupt flag; hardware set wins over clear
   always_ff @(posedge clock_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         toggle_output_flop_r <= 1'b0;
         timer_irq_flag_r <= 1'b0;
      end
      else
      begin
         if (start_r)
            toggle_output_flop_r <= 1'b0;
         else if (match)
            toggle_output_flop_r <= ~toggle_output_flop_r;
         if (match || irq_set_sw)
            timer_irq_flag_r <= 1'b1;
         else if (irq_clr_sw)
            timer_irq_flag_r <= 1'b0;
      end
   end

   // ***************************************************
   // count path
   // ***************************************************
   // gate count pulses with the enable bit
   assign count_pulse = pulse & timer_mode_reg_r[tec_pkg::MODE_ENABLE_BIT];

   tec_prescaler u_prescaler
   (
      .clock_i(clock_i),
      .rst_n_i(rst_n_r),
      .src_i(timer_mode_reg_r[tec_pkg::MODE_SRC_LSB +: 3]),
      .event_i(event_in_pin_i),
      .pulse_o(pulse)
   );

   // counts 0..modulo so the period is modulo plus one pulses
   tec_counter u_counter
   (
      .clock_i(clock_i),
      .rst_n_i(rst_n_r),
      .clear_i(start_r),
      .pulse_i(count_pulse),
      .modulo_i(modulo_reg_r),
      .count_o(count_reg),
      .match_o(match)
   );

   // ***************************************************
   // read data and outputs
   // ***************************************************
   logic [7:0] ctrl_view;
   logic [31:0] rd_data;

   // control/status view
   assign ctrl_view = {3'h0, toggle_output_flop_r, irq_mask_r,
                       event_in_pin_i, timer_irq_flag_r, square_out_enable_flag_r};
   assign rd_data = (req.adr == tec_pkg::ADDR_MODE) ? {24'h00_0000, timer_mode_reg_r} :
                    (req.adr == tec_pkg::ADDR_MODULO) ? {24'h00_0000, modulo_reg_r} :
                    (req.adr == tec_pkg::ADDR_COUNT) ? {24'h00_0000, count_reg} :
                    (req.adr == tec_pkg::ADDR_CTRL) ? {24'h00_0000, ctrl_view} :
                    32'h0000_0000;

   // registered ack, read data and pins
   always_ff @(posedge clock_i or negedge rst_n_r)
   begin
      if (!rst_n_r)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         square_out_pin_o <= 1'b0;
         shift_clock_o <= 1'b0;
         irq_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= access;
         wb_dat_o <= rd ? rd_data : 32'h0000_0000;
         square_out_pin_o <= square_out_enable_flag_r & toggle_output_flop_r;
         shift_clock_o <= toggle_output_flop_r;
         irq_o <= timer_irq_flag_r & irq_mask_r;
      end
   end

endmodule
`default_nettype wire

// ### sim/tec_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// bus and pin checks
// ****
module tec_assertions
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic event_in_pin_i,
   input wire logic square_out_pin_o,
   input wire logic shift_clock_o,
   input wire logic irq_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   // a request not yet answered, and one that sets start
   sequence take_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence start_s;
      take_s ##0 wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h0 && wb_dat_i[3];
   endsequence
   ack_late_a: assert property (take_s |=> wb_ack_o)
      else $error("request not answered");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   idle_data_a: assert property (!wb_ack_o |-> wb_dat_o == '0)
      else $error("data without ack");
   upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == '0)
      else $error("upper bits set");
   start_clear_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> !wb_dat_o[3])
      else $error("start bit stuck");
   hole_zero_a: assert property (wb_ack_o && !(wb_adr_i inside {4'h0, 4'h4, 4'h8, 4'hc})
      |-> wb_dat_o == '0)
      else $error("unmapped data");
   toggle_reset_a: assert property (start_s |-> ##[2:4] !shift_clock_o)
      else $error("toggle not reset");
   out_gate_a: assert property (square_out_pin_o |-> shift_clock_o)
      else $error("pin without toggle");
endmodule
bind tec_top tec_assertions u_chk (.clock_i(clock_i), .nrst_i(nrst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .event_in_pin_i(event_in_pin_i), .square_out_pin_o(square_out_pin_o),
   .shift_clock_o(shift_clock_o), .irq_o(irq_o));
`default_nettype wire

// ### sim/tec_partner.sv
`timescale 1ns/1ns
`default_nettype none
// event source: a burst of n rising edges, idle high between bursts
module tec_partner
(
   input wire logic clock_i,
   input wire logic go_i,
   input wire logic [7:0] n_i,
   output logic event_o,
   output logic done_o
);
   logic run_r = 1'b0;
   logic [10:0] t_r = 11'h0;
   // one rising edge every eight cycles while running
   assign event_o = !run_r || t_r[2];
   assign done_o = !run_r;
   // burst timer
   always_ff @(posedge clock_i)
   begin
      if (go_i)
      begin
         run_r <= 1'b1;
         t_r <= 11'h0;
      end
      else if (run_r)
      begin
         t_r <= t_r + 11'h1;
         run_r <= (t_r + 11'h1 != {n_i, 3'h0});
      end
   end
endmodule
`default_nettype wire

// ### sim/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// self-checking bench
// ****
module testbench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic go = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [7:0] n = 8'h1;
   logic [31:0] rd, q;
   logic ack, ev, done, sq, sc, irq;
   int fails = 0;
   int compares = 0;
   int m, k, c;
   // 50 MHz clock
   initial forever #10 clk = ~clk;
   tec_top u_dut (.clock_i(clk), .nrst_i(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd), .wb_ack_o(ack),
      .event_in_pin_i(ev), .square_out_pin_o(sq), .shift_clock_o(sc), .irq_o(irq));
   tec_partner u_far (.clock_i(clk), .go_i(go), .n_i(n), .event_o(ev), .done_o(done));
   // verdict and end of run
   task automatic results();
      $display("fails %0d compares %0d", fails, compares);
      if (fails == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
      compares++;
      if (v !== e)
      begin
         fails++;
         $display("mismatch %s exp %h seen %h", s, e, v);
      end
   endtask
   // one classic wishbone cycle, held until ack
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r);
      int i;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      i = 0;
      do
      begin
         @(posedge clk);
         i++;
      end
      while (ack !== 1'b1 && i < 40);
      r = rd;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i >= 40)
      begin
         fails++;
         results();
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, {24'h0, d}, 4'hf, q);
   endtask
   task automatic rdc(input string s, input logic [3:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf, q);
      chk(s, q, e);
   endtask
   // waits for the next change of the toggle output
   task automatic tog();
      logic v;
      c = 0;
      v = sc;
      while (sc === v && c < 3000)
      begin
         @(posedge clk);
         c++;
      end
      if (c >= 3000)
      begin
         fails++;
         results();
      end
   endtask
   // main sequence
   initial
   begin
      k = $urandom(32'h4b71);
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      rdc("mode", 4'h0, 32'h0);
      rdc("modulo", 4'h4, 32'hff);
      rdc("ctrl", 4'hc, 32'h4);
      rdc("hole", 4'h6, 32'h0);
      m = $urandom % 7 + 1;
      wr(4'h4, m[7:0]);
      bus(1'b1, 4'h4, 32'h0, 4'he, q);
      rdc("modulo", 4'h4, m);
      wr(4'hc, 8'h09);
      wr(4'h0, 8'h7c);
      rdc("mode", 4'h0, 32'h74);
      tog();
      tog();
      chk("period", c, (m + 1) * 8);
      chk("irq", irq, 1);
      rdc("ctrl", 4'hc, 32'hf);
      repeat (2) @(posedge clk);
      chk("irq", irq, 0);
      wr(4'hc, 8'h03);
      repeat (2) @(posedge clk);
      chk("irq", irq, 0);
      wr(4'hc, 8'h0b);
      repeat (2) @(posedge clk);
      chk("irq", irq, 1);
      wr(4'h0, 8'h78);
      repeat (40) @(posedge clk);
      rdc("count", 4'h8, 32'h0);
      m = $urandom % 7 + 1;
      k = $urandom % 20 + 1;
      wr(4'h4, m[7:0]);
      wr(4'h0, 8'h0c);
      n <= k[7:0];
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      c = 0;
      do
      begin
         @(posedge clk);
         c++;
      end
      while (done !== 1'b1 && c < 400);
      if (c >= 400)
      begin
         fails++;
         results();
      end
      repeat (8) @(posedge clk);
      rdc("count", 4'h8, k % (m + 1));
      chk("toggle", sc, (k / (m + 1)) % 2);
      chk("pin", sq, (k / (m + 1)) % 2);
      wr(4'hc, 8'h08);
      repeat (2) @(posedge clk);
      chk("pin", sq, 0);
      results();
   end
endmodule
`default_nettype wire
